// ---- csou_top.sv ----
// Overview of operation
// RL1: decode register-form load2, move, search, numeric, load3, packed groups
// RL2: decode in-line move, search, numeric, packed groups separately
// RL3: register form uses general registers; in-line reads following words (register-form load2 and load3 take pointer words from the stream)
// RL4: register and in-line forms report the same generic group
// RL5: load-descriptor groups deliver two or three descriptors
// RL6: unpredictable results never spoil descriptor fetches
// RL7: user-mode accesses beyond the mapped limit are never issued
// RL8: such a fault is reported as a proper trap with its address
// RL9: a character's high byte must be zero; else unpredictable (register-form move does not flag R4's high byte)
// RL10: a string is addressed by its lowest byte, the most significant one
// RL11: string length is an unsigned 16-bit character count
// RL12: zero-length strings are vacant and their address is ignored
// RL13: in-line descriptors come from two words behind a pointer word
// RL14: a set descriptor holds a table address and an 8-bit mask
// RL15: member when table byte at base plus char ANDed with mask is nonzero
// RL16: first set descriptor word needs zero high byte; else unpredictable
// RL17: register form: R0-R1, R2-R3 strings, R4 char, R4-R5 set
// RL18: first descriptor word is length or mask, second is address
`timescale 1ns/1ps
module csou_top
  import csou_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        start,
  input  wire logic [15:0] opcode,
  input  wire logic [15:0] pc,
  input  csou_regs_s       regs,
  input  wire logic        user_mode,
  input  wire logic [15:0] map_limit,
  output logic             mem_req,
  output logic      [15:0] mem_adr,
  input  wire logic [15:0] mem_rdata,
  input  wire logic        mem_ack,
  input  wire logic        chk_req,
  input  wire logic [7:0]  chk_char,
  output logic             busy,
  output logic             done,
  output csou_result_s     result,
  output logic [2:0]       vacant,
  output logic [15:0]      last_adr [NUM_DESC],
  output logic             unpredictable,
  output logic             trap,
  output logic      [15:0] trap_adr,
  output logic             member,
  output logic             member_valid
);

  // ----------------------------------------------------------------
  // decode and helpers
  // ----------------------------------------------------------------
  csou_state_e state;
  csou_state_e next_state;
  csou_grp_e   dec_grp;
  logic        dec_inl;
  logic        dec_known;
  logic [1:0]  dec_nslot;
  logic [5:0]  dec_kinds;
  logic [1:0]  nslot;
  logic [5:0]  kinds;
  logic [1:0]  slot;
  logic [1:0]  kind;
  logic [15:0] ptr;
  logic [15:0] tbl_adr;
  logic        issue;
  logic [15:0] issue_adr;
  logic        go_req;
  logic        fault;
  logic        illegal;
  logic        advance;
  logic        fetch_form;

  csou_decode u_decode (
    .opcode (opcode),
    .grp    (dec_grp),
    .inl    (dec_inl),
    .known  (dec_known),
    .nslot  (dec_nslot),
    .kinds  (dec_kinds)
  );

  csou_set_check u_set_check (
    .clock        (clock),
    .reset        (reset),
    .launch       (state == ST_IDLE && go_req && !start),
    .tbl_base     (result.cset.adr),
    .chr_in       (chk_char),
    .mask         (result.cset.mask_word[7:0]),
    .capture      (state == ST_MEMB && mem_ack),
    .rdata        (mem_rdata),
    .tbl_adr      (tbl_adr),
    .member       (member),
    .member_valid (member_valid)
  );

  // load groups always take pointer words from the stream
  assign fetch_form = dec_inl || dec_grp == CSOU_GRP_LOAD2
                      || dec_grp == CSOU_GRP_LOAD3;             // RL3 RL5
  assign kind       = kinds[2*slot +: 2];
  assign busy       = (state != ST_IDLE);
  assign done       = (state == ST_DONE);

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    issue      = 1'b0;
    issue_adr  = ZERO_WORD;
    advance    = 1'b0;
    illegal    = 1'b0;
    case (state)
      ST_IDLE:
      begin
        if (start && !dec_known)
          illegal = 1'b1;
        else if (start && fetch_form)
        begin
          issue      = 1'b1;                                   // RL3
          issue_adr  = pc + WORD_STEP;
          next_state = ST_PTR;
        end
        else if (start)
          next_state = ST_DONE;                                 // RL3
        else if (chk_req)
        begin
          issue      = 1'b1;
          issue_adr  = {tbl_adr[15:1], 1'b0};
          next_state = ST_MEMB;
        end
      end
      ST_PTR:
      begin
        if (mem_ack && kind == K_CHAR)
          advance = 1'b1;
        else if (mem_ack)
        begin
          issue      = 1'b1;                                   // RL13
          issue_adr  = {mem_rdata[15:1], 1'b0};
          next_state = ST_DLEN;
        end
      end
      ST_DLEN:
      begin
        if (mem_ack)
        begin
          issue      = 1'b1;                                   // RL6 RL13
          issue_adr  = ptr + WORD_STEP;
          next_state = ST_DADR;
        end
      end
      ST_DADR:
        advance = mem_ack;
      ST_MEMB:
        if (mem_ack)
          next_state = ST_IDLE;
      ST_DONE:
        next_state = ST_IDLE;
      default:
        next_state = ST_IDLE;
    endcase
    if (advance && slot == nslot - 2'h1)
      next_state = ST_DONE;
    else if (advance)
    begin
      issue      = 1'b1;
      issue_adr  = pc + WORD_STEP + {13'h0000, slot + 2'h1, 1'b0};
      next_state = ST_PTR;
    end
    // out-of-map user access: drop it, report a trap instead
    fault  = issue && user_mode && issue_adr > map_limit;      // RL7
    go_req = issue && !fault;
    if (fault)
      next_state = ST_IDLE;                                    // RL8
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      mem_req <= 1'b0;
      mem_adr <= ZERO_WORD;
    end
    else if (go_req)
    begin
      mem_req <= 1'b1;
      mem_adr <= issue_adr;
    end
    else if (mem_ack)
      mem_req <= 1'b0;
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      trap     <= 1'b0;
      trap_adr <= ZERO_WORD;
    end
    else
    begin
      trap <= fault || illegal;                                // RL8
      if (fault)
        trap_adr <= issue_adr;
      else if (illegal)
        trap_adr <= pc;
    end
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      slot  <= 2'h0;
      ptr   <= ZERO_WORD;
      nslot <= 2'h0;
      kinds <= 6'h00;
    end
    else
    begin
      if (state == ST_IDLE && start)
      begin
        slot  <= 2'h0;
        nslot <= dec_nslot;
        kinds <= dec_kinds;
      end
      else if (advance)
        slot <= slot + 2'h1;
      if (state == ST_PTR && mem_ack)
        ptr <= {mem_rdata[15:1], 1'b0};
    end
  end

  // ----------------------------------------------------------------
  // operand capture
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      result <= '0;
    else if (state == ST_IDLE && start && dec_known)
    begin
      result.grp <= dec_grp;                                   // RL4
      result.inl <= dec_inl;
      if (!fetch_form)
      begin
        result.opnd[0] <= '{len: regs.r0, adr: regs.r1};       // RL17 RL18
        result.opnd[1] <= '{len: regs.r2, adr: regs.r3};       // RL17 RL18
        result.opnd[2] <= '0;
        result.chr     <= regs.r4[7:0];                        // RL17
        result.cset    <= '{mask_word: regs.r4, adr: regs.r5}; // RL14 RL17
      end
    end
    else if (mem_ack)
    begin
      if (state == ST_PTR && kind == K_CHAR)
        result.chr <= mem_rdata[7:0];                          // RL3
      else if (state == ST_DLEN && kind == K_SET)
        result.cset.mask_word <= mem_rdata;                    // RL14 RL18
      else if (state == ST_DLEN)
        result.opnd[slot].len <= mem_rdata;                    // RL11 RL18
      else if (state == ST_DADR && kind == K_SET)
        result.cset.adr <= mem_rdata;
      else if (state == ST_DADR)
        result.opnd[slot].adr <= mem_rdata;                    // RL5 RL18
    end
  end

  // flag nonzero character and mask high bytes, except R4 in register-form move; descriptors are still fetched as usual
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      unpredictable <= 1'b0;
    else if (state == ST_IDLE && start)
      unpredictable <= !fetch_form && dec_grp == CSOU_GRP_SEARCH
                       && regs.r4[15:8] != ZERO_BYTE;          // RL9 RL16
    else if (mem_ack && mem_rdata[15:8] != ZERO_BYTE
             && ((state == ST_PTR && kind == K_CHAR)
                 || (state == ST_DLEN && kind == K_SET)))
      unpredictable <= 1'b1;                                   // RL6 RL9 RL16
  end

  // per-descriptor vacancy and least significant character address
  genvar gi;
  generate
    for (gi = 0; gi < NUM_DESC; gi++)
    begin : g_desc
      assign vacant[gi]   = (result.opnd[gi].len == ZERO_WORD); // RL12
      // lowest byte holds the most significant character
      assign last_adr[gi] = vacant[gi] ? ZERO_WORD               // RL12
                          : result.opnd[gi].adr
                            + result.opnd[gi].len - ONE;       // RL10 RL11
    end
  endgenerate

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_map_limit;
    @(posedge clock) disable iff (reset)
    mem_req && (!$past(mem_req) || $past(mem_ack)) && $past(user_mode)
    |-> mem_adr <= $past(map_limit);
  endproperty
  a_map_limit: assert property (p_map_limit) // RL7
    else $error("user access issued beyond mapped limit");

  property p_trap;
    @(posedge clock) disable iff (reset)
    fault |=> trap && trap_adr == $past(issue_adr) && state == ST_IDLE;
  endproperty
  a_trap: assert property (p_trap) // RL8
    else $error("fault not reported as trap");

  property p_reg_form;
    @(posedge clock) disable iff (reset)
    state == ST_IDLE && start && dec_known && !fetch_form
    |=> result.opnd[0].len == $past(regs.r0)
        && result.opnd[1].adr == $past(regs.r3)
        && result.cset.adr == $past(regs.r5) && done && !mem_req;
  endproperty
  a_reg_form: assert property (p_reg_form) // RL17
    else $error("register form operands not taken from registers");

  property p_inline_fetch;
    @(posedge clock) disable iff (reset)
    state == ST_IDLE && start && fetch_form && !fault
    |=> mem_req && mem_adr == $past(pc) + WORD_STEP;
  endproperty
  a_inline_fetch: assert property (p_inline_fetch) // RL3
    else $error("in-line form did not fetch the word after opcode");

  property p_load2;
    @(posedge clock) disable iff (reset)
    state == ST_IDLE && start && (opcode & OPC_MASK) == OPC_LOAD2
    |=> result.grp == CSOU_GRP_LOAD2 && nslot == 2'h2;
  endproperty
  a_load2: assert property (p_load2) // RL1
    else $error("load two descriptors group misdecoded");

  property p_inline_grp;
    @(posedge clock) disable iff (reset)
    state == ST_IDLE && start && (opcode & OPC_MASK) == OPC_PACKED_I
    |=> result.inl && result.grp == CSOU_GRP_PACKED;
  endproperty
  a_inline_grp: assert property (p_inline_grp) // RL2
    else $error("in-line packed group misdecoded");

  property p_desc_pair;
    @(posedge clock) disable iff (reset)
    state == ST_DLEN && mem_ack && !fault
    |=> mem_req && mem_adr == $past(ptr) + WORD_STEP;
  endproperty
  a_desc_pair: assert property (p_desc_pair) // RL13
    else $error("descriptor second word not fetched");

  property p_char_hi;
    @(posedge clock) disable iff (reset)
    state == ST_PTR && mem_ack && kind == K_CHAR
    && mem_rdata[15:8] != ZERO_BYTE |=> unpredictable;
  endproperty
  a_char_hi: assert property (p_char_hi) // RL9
    else $error("nonzero character high byte not flagged");

  c_reg_done: cover property (@(posedge clock)
    done && !result.inl && result.grp == CSOU_GRP_MOVE);
  c_inline_done: cover property (@(posedge clock)
    done && result.inl && result.grp == CSOU_GRP_SEARCH);
  c_trap: cover property (@(posedge clock) trap);
  c_unpred: cover property (@(posedge clock) done && unpredictable);

endmodule // csou_top

// ---- csou_pkg.sv ----
package csou_pkg;

  // ----------------------------------------------------------------
  // opcode groups (octal groups written in hex, low three bits free)
  // ----------------------------------------------------------------
  localparam logic [15:0] OPC_MASK      = 16'hFFF8;
  localparam logic [15:0] OPC_LOAD2     = 16'h7C10;
  localparam logic [15:0] OPC_MOVE      = 16'h7C18;
  localparam logic [15:0] OPC_SEARCH    = 16'h7C20;
  localparam logic [15:0] OPC_NUMERIC   = 16'h7C28;
  localparam logic [15:0] OPC_LOAD3     = 16'h7C30;
  localparam logic [15:0] OPC_PACKED    = 16'h7C38;
  localparam logic [15:0] OPC_MOVE_I    = 16'h7C58;
  localparam logic [15:0] OPC_SEARCH_I  = 16'h7C60;
  localparam logic [15:0] OPC_NUMERIC_I = 16'h7C68;
  localparam logic [15:0] OPC_PACKED_I  = 16'h7C78;
  localparam int          INLINE_BIT    = 6;

  // ----------------------------------------------------------------
  // addressing and operand layout
  // ----------------------------------------------------------------
  localparam logic [15:0] WORD_STEP     = 16'h0002;
  localparam logic [15:0] ONE           = 16'h0001;
  localparam logic [15:0] ZERO_WORD     = 16'h0000;
  localparam logic [7:0]  ZERO_BYTE     = 8'h00;
  localparam int          NUM_DESC      = 3;
  localparam logic [1:0]  K_DESC        = 2'h0;
  localparam logic [1:0]  K_CHAR        = 2'h1;
  localparam logic [1:0]  K_SET         = 2'h2;

  typedef enum logic [2:0] {
    CSOU_GRP_NONE    = 3'h0,
    CSOU_GRP_LOAD2   = 3'h1,
    CSOU_GRP_MOVE    = 3'h2,
    CSOU_GRP_SEARCH  = 3'h3,
    CSOU_GRP_NUMERIC = 3'h4,
    CSOU_GRP_LOAD3   = 3'h5,
    CSOU_GRP_PACKED  = 3'h6
  } csou_grp_e;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_PTR  = 6'h02,
    ST_DLEN = 6'h04,
    ST_DADR = 6'h08,
    ST_MEMB = 6'h10,
    ST_DONE = 6'h20
  } csou_state_e;

  typedef struct packed {
    logic [15:0] len;
    logic [15:0] adr;
  } csou_desc_s;

  typedef struct packed {
    logic [15:0] mask_word;
    logic [15:0] adr;
  } csou_cset_s;

  typedef struct packed {
    logic [15:0] r0;
    logic [15:0] r1;
    logic [15:0] r2;
    logic [15:0] r3;
    logic [15:0] r4;
    logic [15:0] r5;
  } csou_regs_s;

  typedef struct packed {
    csou_grp_e                   grp;
    logic                        inl;
    csou_desc_s [NUM_DESC-1:0]   opnd;
    logic [7:0]                  chr;
    csou_cset_s                  cset;
  } csou_result_s;

endpackage

// ---- csou_decode.sv ----
`timescale 1ns/1ps
module csou_decode
  import csou_pkg::*;
(
  input  wire logic [15:0] opcode,
  output csou_grp_e        grp,
  output logic             inl,
  output logic             known,
  output logic [1:0]       nslot,
  output logic [5:0]       kinds
);

  logic [1:0] search_kind;

  // opcode bits 2:1 pick the second search operand: char, set or string
  always_comb
  begin
    case (opcode[2:1])
      2'h0:    search_kind = K_CHAR;
      2'h1:    search_kind = K_SET;
      default: search_kind = K_DESC;
    endcase
  end

  always_comb
  begin
    grp   = CSOU_GRP_NONE;
    nslot = 2'h0;
    kinds = {K_DESC, K_DESC, K_DESC};
    case (opcode & OPC_MASK)
      OPC_LOAD2:                          // RL1
      begin
        grp   = CSOU_GRP_LOAD2;
        nslot = 2'h2;
      end
      OPC_LOAD3:                          // RL1
      begin
        grp   = CSOU_GRP_LOAD3;
        nslot = 2'h3;
      end
      OPC_MOVE, OPC_MOVE_I:               // RL1 RL2
      begin
        grp   = CSOU_GRP_MOVE;
        nslot = 2'h3;
        kinds = {K_CHAR, K_DESC, K_DESC};
      end
      OPC_SEARCH, OPC_SEARCH_I:           // RL1 RL2
      begin
        grp   = CSOU_GRP_SEARCH;
        nslot = 2'h2;
        kinds = {K_DESC, search_kind, K_DESC};
      end
      OPC_NUMERIC, OPC_NUMERIC_I:         // RL1 RL2
      begin
        grp   = CSOU_GRP_NUMERIC;
        nslot = 2'h3;
      end
      OPC_PACKED, OPC_PACKED_I:           // RL1 RL2
      begin
        grp   = CSOU_GRP_PACKED;
        nslot = 2'h3;
      end
      default:
      begin
        grp   = CSOU_GRP_NONE;
      end
    endcase
  end

  assign known = (grp != CSOU_GRP_NONE);
  assign inl   = known && opcode[INLINE_BIT];   // RL2

endmodule // csou_decode

// ---- csou_set_check.sv ----
`timescale 1ns/1ps
module csou_set_check
  import csou_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        launch,
  input  wire logic [15:0] tbl_base,
  input  wire logic [7:0]  chr_in,
  input  wire logic [7:0]  mask,
  input  wire logic        capture,
  input  wire logic [15:0] rdata,
  output logic      [15:0] tbl_adr,
  output logic             member,
  output logic             member_valid
);

  logic       sel_hi;
  logic [7:0] mask_q;
  logic [7:0] entry;

  // table byte sits at base plus character value
  assign tbl_adr = tbl_base + {ZERO_BYTE, chr_in};            // RL15
  assign entry   = sel_hi ? rdata[15:8] : rdata[7:0];

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      sel_hi <= 1'b0;
      mask_q <= ZERO_BYTE;
    end
    else if (launch)
    begin
      sel_hi <= tbl_adr[0];
      mask_q <= mask;                                         // RL14
    end
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      member       <= 1'b0;
      member_valid <= 1'b0;
    end
    else
    begin
      member_valid <= capture;
      if (capture)
        member <= |(entry & mask_q);                          // RL15
    end
  end

  property p_member;
    @(posedge clock) disable iff (reset)
    capture |=> member_valid
                && (member == |($past(entry) & $past(mask)));
  endproperty
  a_member: assert property (p_member) // RL15
    else $error("membership result does not match table and mask");

  c_member: cover property (@(posedge clock) member_valid && member);

endmodule // csou_set_check

// ---- csou_mem_model.sv ----
`timescale 1ns/1ps
module csou_mem_model
(
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        slow,
  input  wire logic        mem_req,
  input  wire logic [15:0] mem_adr,
  output logic      [15:0] mem_rdata,
  output logic             mem_ack
);
  // -------------------------------------------------------------
  // word memory, read only from the block's side
  // -------------------------------------------------------------
  logic [15:0] mem [32768];
  logic [1:0]  wait_cnt;

  // one read at a time; slow adds two wait cycles before the ack
  always @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      mem_ack   <= 1'b0;
      mem_rdata <= 16'h5A5A;
      wait_cnt  <= 2'h0;
    end
    else if (mem_req && !mem_ack && (!slow || wait_cnt == 2'h2))
    begin
      mem_ack   <= 1'b1;
      mem_rdata <= mem[mem_adr[15:1]];
      wait_cnt  <= 2'h0;
    end
    else
    begin
      mem_ack   <= 1'b0;
      // stale data keeps toggling so it can never pass for a fresh read
      mem_rdata <= ~mem_rdata;
      wait_cnt  <= (mem_req && !mem_ack) ? wait_cnt + 2'h1 : 2'h0;
    end
  end
endmodule // csou_mem_model

// ---- csou_tb_top.sv ----
`timescale 1ns/1ps
module csou_tb_top
  import csou_pkg::*;
;
  logic         clock, reset, start, user_mode, chk_req, slow;
  logic         mem_req, mem_ack, busy, done, unpredictable, trap;
  logic         member, member_valid;
  logic [15:0]  opcode, pc, map_limit, mem_adr, mem_rdata, trap_adr, rnd;
  logic [7:0]   chk_char;
  logic [7:0]   tbl [256];
  logic [2:0]   vacant;
  logic [15:0]  last_adr [NUM_DESC];
  csou_regs_s   regs;
  csou_result_s result;
  int           fail_count, checked, cyc;

  csou_top csou_top_i (.clock, .reset, .start, .opcode, .pc, .regs,
    .user_mode, .map_limit, .mem_req, .mem_adr, .mem_rdata, .mem_ack,
    .chk_req, .chk_char, .busy, .done, .result, .vacant, .last_adr,
    .unpredictable, .trap, .trap_adr, .member, .member_valid);
  csou_mem_model csou_mem_model_i (.clock, .reset, .slow, .mem_req,
    .mem_adr, .mem_rdata, .mem_ack);

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic [15:0] exp_last(input csou_desc_s x);
    return (x.len == 16'h0000) ? 16'h0000 : x.adr + x.len - 16'h0001;
  endfunction

  task automatic check(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1)
    begin
      fail_count++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask

  task automatic roll();
    rnd = lfsr(rnd);
  endtask

  task automatic put(input logic [15:0] a, input logic [15:0] w);
    csou_mem_model_i.mem[a[15:1]] = w;
  endtask

  task automatic go(input logic [15:0] op);
    @(posedge clock) #1;
    opcode = op;
    start  = 1'b1;
    roll();
    slow   = rnd[0];
    @(posedge clock) #1;
    start = 1'b0;
    for (cyc = 0; cyc < 200 && done !== 1'b1 && trap !== 1'b1; cyc++)
      @(posedge clock) #1;
  endtask

  task automatic check_desc(input int i, input csou_desc_s x);
    check(result.opnd[i] === x, "descriptor");
    check(vacant[i] === (x.len == 16'h0000), "vacant flag");
    check(last_adr[i] === exp_last(x), "last address");
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // -------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------
  task automatic reg_form();
    csou_grp_e   eg [4];
    logic [15:0] op [4];
    eg = '{CSOU_GRP_MOVE, CSOU_GRP_SEARCH, CSOU_GRP_NUMERIC, CSOU_GRP_PACKED};
    op = '{OPC_MOVE, OPC_SEARCH, OPC_NUMERIC, OPC_PACKED};
    for (int j = 0; j < 8; j++)
    begin
      for (int k = 0; k < 6; k++)
      begin
        roll();
        regs = {regs[79:0], rnd};
      end
      if (j == 0)
        regs.r0 = 16'h0000;
      regs.r4[15:8] = (j < 4) ? 8'h00 : (regs.r4[15:8] | 8'h01);
      go(op[j % 4]);
      check(cyc == 0, "register form latency");
      check(result.grp === eg[j % 4] && result.inl === 1'b0, "group");
      check_desc(0, csou_desc_s'{regs.r0, regs.r1});
      check_desc(1, csou_desc_s'{regs.r2, regs.r3});
      check_desc(2, '0);
      check(result.chr === regs.r4[7:0], "character");
      check(result.cset === csou_cset_s'{regs.r4, regs.r5}, "set");
      if (j % 4 == 1)
        check(unpredictable === (j >= 4), "high byte flag");
    end
    $display("test register forms done");
  endtask

  task automatic inline_run(input logic [15:0] op, input int n,
                            input csou_grp_e g, input logic [7:0] hb);
    csou_desc_s  x [NUM_DESC];
    logic [15:0] ptr;
    logic [7:0]  ch;
    pc = 16'h1000;
    for (int i = 0; i < n; i++)
    begin
      ptr = 16'h2000 + 16'(8 * i);
      roll();
      // slot one stays vacant to show its address is ignored
      x[i].len = (i == 1) ? 16'h0000 : rnd;
      roll();
      x[i].adr = rnd;
      put(pc + 16'(2 + 2 * i), ptr);
      put(ptr, x[i].len);
      put(ptr + WORD_STEP, x[i].adr);
    end
    roll();
    ch = rnd[7:0];
    put(pc + 16'(2 + 2 * n), {hb, ch});
    go(op);
    check(done === 1'b1, "in-line completion");
    check(result.grp === g, "in-line group");
    check(result.inl === op[INLINE_BIT], "in-line mark");
    for (int i = 0; i < n; i++)
      check_desc(i, x[i]);
    if (g == CSOU_GRP_MOVE || g == CSOU_GRP_SEARCH)
    begin
      check(result.chr === ch, "in-line character");
      check(unpredictable === (hb != 8'h00), "high byte flag");
    end
  endtask

  task automatic set_run(input logic [7:0] hb, input logic [7:0] mask);
    logic [15:0] a;
    pc = 16'h1000;
    put(16'h1002, 16'h2000);
    put(16'h2000, 16'h0005);
    put(16'h2002, 16'h3000);
    put(16'h1004, 16'h2010);
    put(16'h2010, {hb, mask});
    // odd table base exercises the high-byte lane of the table word
    put(16'h2012, 16'h4001);
    for (int c = 0; c < 256; c++)
    begin
      roll();
      tbl[c] = rnd[7:0];
      a = 16'h4001 + 16'(c);
      if (a[0])
        csou_mem_model_i.mem[a[15:1]][15:8] = tbl[c];
      else
        csou_mem_model_i.mem[a[15:1]][7:0] = tbl[c];
    end
    go(OPC_SEARCH_I | 16'h0002);
    check(result.cset === csou_cset_s'{{hb, mask}, 16'h4001}, "set");
    check(unpredictable === (hb != 8'h00), "set high byte flag");
    for (int k = 0; k < 12; k++)
    begin
      roll();
      @(posedge clock) #1;
      chk_char = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : rnd[7:0];
      chk_req  = 1'b1;
      @(posedge clock) #1;
      chk_req = 1'b0;
      for (cyc = 0; cyc < 50 && member_valid !== 1'b1; cyc++)
        @(posedge clock) #1;
      check(member_valid === 1'b1, "membership answer");
      check(member === |(tbl[chk_char] & mask), "membership");
    end
    $display("test character set done");
  endtask

  task automatic trap_run();
    pc = 16'h1000;
    go(16'h7C48);
    check(trap === 1'b1 && done !== 1'b1, "unknown opcode");
    check(trap_adr === pc, "unknown opcode address");
    check(busy === 1'b0, "idle after unknown opcode");
    user_mode = 1'b1;
    map_limit = 16'h1FFF;
    put(16'h1002, 16'h3000);
    go(OPC_SEARCH_I);
    check(trap === 1'b1 && done !== 1'b1, "blocked access");
    check(trap_adr === 16'h3000, "blocked address");
    check(busy === 1'b0 && mem_req === 1'b0, "idle after block");
    @(posedge clock) #1;
    user_mode = 1'b0;
    map_limit = 16'hFFFF;
    $display("test traps done");
  endtask

  // user programs must never see a read beyond their mapped limit
  always @(posedge clock)
    if (mem_req === 1'b1 && user_mode === 1'b1 && mem_adr > map_limit)
      check(1'b0, "access beyond map limit");

  initial
  begin
    #300000;
    fail_count++;
    finish_test();
  end

  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial
  begin
    rnd       = 16'h000F;
    reset     = 1'b1;
    start     = 1'b0;
    opcode    = 16'h0000;
    pc        = 16'h0000;
    regs      = '0;
    user_mode = 1'b0;
    map_limit = 16'hFFFF;
    chk_req   = 1'b0;
    chk_char  = 8'h00;
    slow      = 1'b0;
    repeat (12) @(posedge clock);
    #1;
    check(busy === 1'b0 && mem_req === 1'b0, "reset");
    check(vacant === 3'h7 && last_adr[0] === 16'h0000, "reset vacant");
    reset = 1'b0;
    reg_form();
    for (int t = 0; t < 12; t++)
      inline_run(t % 6 == 0 ? OPC_LOAD2 : t % 6 == 1 ? OPC_LOAD3 :
                 t % 6 == 2 ? OPC_MOVE_I : t % 6 == 3 ? OPC_SEARCH_I :
                 t % 6 == 4 ? OPC_NUMERIC_I : OPC_PACKED_I,
                 t % 6 == 0 ? 2 : t % 6 == 1 ? 3 : t % 6 == 2 ? 2 :
                 t % 6 == 3 ? 1 : 3,
                 t % 6 == 0 ? CSOU_GRP_LOAD2 : t % 6 == 1 ? CSOU_GRP_LOAD3 :
                 t % 6 == 2 ? CSOU_GRP_MOVE : t % 6 == 3 ? CSOU_GRP_SEARCH :
                 t % 6 == 4 ? CSOU_GRP_NUMERIC : CSOU_GRP_PACKED,
                 t < 6 ? 8'h00 : 8'h3C);
    $display("test in-line forms done");
    set_run(8'h00, 8'h07);
    set_run(8'h21, rnd[7:0]);
    trap_run();
    finish_test();
  end
endmodule // csou_tb_top
